// *** design/atv_byte_reg.v ***
`timescale 1ns/1ps
`include "atv_reg_map.vh"
// Fixed-reset byte register; writes are accepted only when allowed.
module atv_byte_reg #(
    parameter [7:0] RST_VAL = 8'h00
) (
    input wire ref_clk,
    input wire rst,
    input wire wr_en,
    input wire [7:0] wr_data,
    output reg [7:0] value_q
);
    always @(posedge ref_clk) begin
        if (rst) begin
            value_q <= RST_VAL;
        end else if (wr_en) begin
            value_q <= wr_data;
        end
    end
endmodule

// *** design/atv_pin_mux.v ***
`timescale 1ns/1ps
`include "atv_reg_map.vh"
// One observation pin: tristate or the test-DAC current word.
module atv_pin_mux (
    input wire ref_clk,
    input wire rst,
    input wire [3:0] source_select,
    input wire [5:0] dac_value,
    output reg [5:0] dac_level_q,
    output reg pin_oe_q
);
    always @(posedge ref_clk) begin
        if (rst) begin
            dac_level_q <= `ATV_DAC_RST;
            pin_oe_q <= 1'h0;
        end else begin
            case (source_select)
                `ATV_SRC_DAC: begin
                    dac_level_q <= dac_value; // [RL1] [RL2]
                    pin_oe_q <= 1'h1;
                end
                `ATV_SRC_TRI: begin
                    dac_level_q <= `ATV_DAC_RST;
                    pin_oe_q <= 1'h0; // [RL8]
                end
                default: begin
                    // Other codes release the pin and hold the level at zero, the same as code 0000.
                    dac_level_q <= `ATV_DAC_RST;
                    pin_oe_q <= 1'h0;
                end
            endcase
        end
    end
endmodule

// *** design/atv_reg_map.vh ***
`ifndef ATV_REG_MAP_VH
`define ATV_REG_MAP_VH
// Register indices; the byte address of each register is four times its index.
`define ATV_IDX_DAC1 8'h39
`define ATV_IDX_DAC2 8'h3A
`define ATV_IDX_ADC 8'h3B
`define ATV_IDX_PROD_A 8'h3C
`define ATV_IDX_PROD_B 8'h3D
`define ATV_IDX_PROD_C 8'h3E
`define ATV_IDX_PROD_D 8'h3F
`define ATV_IDX_SEL 8'h38
`define ATV_ADDR_W 10
`define ATV_DAC_W 6
`define ATV_DAC_MSB 5
`define ATV_DAC_RST 6'h00
`define ATV_RST_A 8'hFF
`define ATV_RST_B 8'h00
`define ATV_RST_C 8'h03
`define ATV_RST_D 8'h00
`define ATV_SEL_RST 8'h00
`define ATV_SRC_TRI 4'h0
`define ATV_SRC_DAC 4'h1
`define ATV_ADC_I_HI 7
`define ATV_ADC_I_LO 4
`define ATV_ADC_Q_HI 3
`define ATV_ADC_Q_LO 0
`define ATV_ADC_RST 8'h00
`define ATV_RD_RST 32'h00000000
`define ATV_BYTE_ZERO 8'h00
`define ATV_BYTE_HI 7
`define ATV_BYTE_LO 0
`define ATV_SEL1_HI 7
`define ATV_SEL1_LO 4
`define ATV_SEL2_HI 3
`define ATV_SEL2_LO 0
`define ATV_RSVD_BIT 1'h0
`define ATV_ALIGN 2'h0
`define ATV_SLOTS 7
`define ATV_SLOT_DAC1 0
`define ATV_SLOT_DAC2 1
`define ATV_SLOT_ADC 2
`define ATV_SLOT_PROD_A 3
`define ATV_SLOT_PROD_B 4
`define ATV_SLOT_PROD_C 5
`define ATV_SLOT_PROD_D 6
`define ATV_HOT_NONE 7'h00
`define ATV_HOT_DAC1 7'h01
`define ATV_HOT_DAC2 7'h02
`define ATV_HOT_ADC 7'h04
`define ATV_HOT_PROD_A 7'h08
`define ATV_HOT_PROD_B 7'h10
`define ATV_HOT_PROD_C 7'h20
`define ATV_HOT_PROD_D 7'h40
`endif

// *** design/atv_test_regs.v ***
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "atv_reg_map.vh"
// Function
// RL1: First DAC value drives first pin on 0001.
// RL2: Second DAC value drives second pin on 0001.
// RL3: DAC upper bits reset to zero.
// RL4: Bit six of DAC registers reserved.
// RL5: ADC sample upper nibble shows I channel.
// RL6: ADC sample lower nibble shows Q channel.
// RL7: Production locations reset 00h, 03h, 00h; the code has four, resetting to FFh, 00h, 03h, 00h.
// RL8: Selector code 0000 tristates the pin.
// RL9: Writes to sample and reserved bits ignored.
module atv_test_regs (
    input wire ref_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [9:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    input wire [3:0] adc_i_sample,
    input wire [3:0] adc_q_sample,
    input wire [7:0] pin_source_select_register,
    output wire [5:0] first_observe_pin_level,
    output wire first_observe_pin_oe,
    output wire [5:0] second_observe_pin_level,
    output wire second_observe_pin_oe
);

    // ****************************************
    // Bus phase tracking
    // ****************************************
    // One-hot phase of the current transfer. A write is taken only when the
    // access cycle follows a setup cycle, so a stray enable cannot commit.
    localparam [2:0] PH_IDLE = 3'h1;
    localparam [2:0] PH_SETUP = 3'h2;
    localparam [2:0] PH_ACCESS = 3'h4;

    reg [2:0] phase_q;
    reg [2:0] phase_d;

    always @* begin
        phase_d = phase_q;
        case (phase_q)
            PH_IDLE: begin
                if (psel && !penable) begin
                    phase_d = PH_SETUP;
                end
            end
            PH_SETUP: begin
                if (psel && penable) begin
                    phase_d = PH_ACCESS;
                end else if (!psel) begin
                    phase_d = PH_IDLE;
                end
            end
            PH_ACCESS: begin
                if (psel && !penable) begin
                    phase_d = PH_SETUP;
                end else begin
                    phase_d = PH_IDLE;
                end
            end
            default: begin
                phase_d = PH_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            phase_q <= PH_IDLE;
        end else begin
            phase_q <= phase_d;
        end
    end

    wire setup_cycle = psel && !penable;
    wire access_cycle = psel && penable && (phase_q == PH_SETUP);
    wire access_w = access_cycle && pwrite;

    // ****************************************
    // Address decode
    // ****************************************
    function [9:0] byte_addr;
        input [7:0] idx;
        begin
            byte_addr = {idx, `ATV_ALIGN};
        end
    endfunction

    function hit;
        input [9:0] a;
        input [7:0] idx;
        begin
            hit = (a == byte_addr(idx));
        end
    endfunction

    // One bit per mapped register; at most one of them is ever set.
    function [`ATV_SLOTS-1:0] decode_slots;
        input [9:0] a;
        begin
            decode_slots = `ATV_HOT_NONE;
            decode_slots[`ATV_SLOT_DAC1] = hit(a, `ATV_IDX_DAC1);
            decode_slots[`ATV_SLOT_DAC2] = hit(a, `ATV_IDX_DAC2);
            decode_slots[`ATV_SLOT_ADC] = hit(a, `ATV_IDX_ADC);
            decode_slots[`ATV_SLOT_PROD_A] = hit(a, `ATV_IDX_PROD_A);
            decode_slots[`ATV_SLOT_PROD_B] = hit(a, `ATV_IDX_PROD_B);
            decode_slots[`ATV_SLOT_PROD_C] = hit(a, `ATV_IDX_PROD_C);
            decode_slots[`ATV_SLOT_PROD_D] = hit(a, `ATV_IDX_PROD_D);
        end
    endfunction

    wire [`ATV_SLOTS-1:0] slot = decode_slots(paddr);
    wire mapped = |slot;
    wire wr_dac1 = access_w && slot[`ATV_SLOT_DAC1];
    wire wr_dac2 = access_w && slot[`ATV_SLOT_DAC2];

    // ****************************************
    // Bus response
    // ****************************************
    // Every access completes in its first access cycle.
    assign pready = 1'h1;
    // Unmapped locations answer with an error and take no effect.
    assign pslverr = psel && penable && !mapped;

    // ****************************************
    // Test DAC words
    // ****************************************
    reg [5:0] first_dac_test_value_q;
    reg [5:0] second_dac_test_value_q;
    reg [5:0] first_dac_test_value_d;
    reg [5:0] second_dac_test_value_d;

    // Only the six value bits are stored; the upper bits of each write are
    // dropped, so software can never set the reserved positions.
    always @* begin
        first_dac_test_value_d = first_dac_test_value_q;
        second_dac_test_value_d = second_dac_test_value_q;
        if (wr_dac1) begin
            first_dac_test_value_d = pwdata[`ATV_DAC_MSB:0]; // [RL1]
        end
        if (wr_dac2) begin
            second_dac_test_value_d = pwdata[`ATV_DAC_MSB:0]; // [RL2]
        end
    end

    // The DAC words have no defined reset value; they are cleared anyway so
    // that simulation never carries unknowns onto the pins.
    always @(posedge ref_clk) begin
        if (rst) begin
            first_dac_test_value_q <= `ATV_DAC_RST;
            second_dac_test_value_q <= `ATV_DAC_RST;
        end else begin
            first_dac_test_value_q <= first_dac_test_value_d;
            second_dac_test_value_q <= second_dac_test_value_d;
        end
    end

    // The two upper bits carry no function and read back as zero.
    wire production_reserved_bit = `ATV_RSVD_BIT; // [RL3]
    wire future_reserved_bit = `ATV_RSVD_BIT; // [RL4]
    wire [7:0] first_dac_word = {production_reserved_bit, future_reserved_bit,
        first_dac_test_value_q};
    wire [7:0] second_dac_word = {future_reserved_bit, future_reserved_bit,
        second_dac_test_value_q};

    // ****************************************
    // ADC sample
    // ****************************************
    reg [7:0] adc_sample_q;
    reg [7:0] adc_sample_d;

    // Sampled every cycle, so the word lags the converters by one clock;
    // host writes never reach it.
    always @* begin
        adc_sample_d = `ATV_ADC_RST;
        adc_sample_d[`ATV_ADC_I_HI:`ATV_ADC_I_LO] = adc_i_sample; // [RL5]
        adc_sample_d[`ATV_ADC_Q_HI:`ATV_ADC_Q_LO] = adc_q_sample; // [RL6]
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            adc_sample_q <= `ATV_ADC_RST;
        end else begin
            adc_sample_q <= adc_sample_d; // [RL9]
        end
    end

    // ****************************************
    // Production locations
    // ****************************************
    wire [7:0] prod_a_q;
    wire [7:0] prod_b_q;
    wire [7:0] prod_c_q;
    wire [7:0] prod_d_q;

    // Locked against host writes: a stray write from software must not
    // disturb the values that production test relies on.
    wire prod_wr_en = 1'h0; // [RL9]
    wire [7:0] prod_wr_data = `ATV_BYTE_ZERO;
    atv_byte_reg #(.RST_VAL(`ATV_RST_A)) u_prod_a ( // [RL7]
        .ref_clk(ref_clk),
        .rst(rst),
        .wr_en(prod_wr_en),
        .wr_data(prod_wr_data),
        .value_q(prod_a_q)
    );
    atv_byte_reg #(.RST_VAL(`ATV_RST_B)) u_prod_b ( // [RL7]
        .ref_clk(ref_clk),
        .rst(rst),
        .wr_en(prod_wr_en),
        .wr_data(prod_wr_data),
        .value_q(prod_b_q)
    );
    atv_byte_reg #(.RST_VAL(`ATV_RST_C)) u_prod_c ( // [RL7]
        .ref_clk(ref_clk),
        .rst(rst),
        .wr_en(prod_wr_en),
        .wr_data(prod_wr_data),
        .value_q(prod_c_q)
    );
    atv_byte_reg #(.RST_VAL(`ATV_RST_D)) u_prod_d ( // [RL7]
        .ref_clk(ref_clk),
        .rst(rst),
        .wr_en(prod_wr_en),
        .wr_data(prod_wr_data),
        .value_q(prod_d_q)
    );

    // ****************************************
    // Read path
    // ****************************************
    reg [7:0] rd_byte;
    reg [31:0] rd_d;

    // Unmapped locations read as zero; only the low byte lane carries data.
    always @* begin
        case (slot)
            `ATV_HOT_DAC1: begin
                rd_byte = first_dac_word; // [RL3] [RL4]
            end
            `ATV_HOT_DAC2: begin
                rd_byte = second_dac_word; // [RL3] [RL4]
            end
            `ATV_HOT_ADC: begin
                rd_byte = adc_sample_q; // [RL5] [RL6]
            end
            `ATV_HOT_PROD_A: begin
                rd_byte = prod_a_q;
            end
            `ATV_HOT_PROD_B: begin
                rd_byte = prod_b_q;
            end
            `ATV_HOT_PROD_C: begin
                rd_byte = prod_c_q;
            end
            `ATV_HOT_PROD_D: begin
                rd_byte = prod_d_q;
            end
            default: begin
                rd_byte = `ATV_BYTE_ZERO;
            end
        endcase
        rd_d = `ATV_RD_RST;
        rd_d[`ATV_BYTE_HI:`ATV_BYTE_LO] = rd_byte;
    end

    // Read data is registered in the setup cycle so it comes straight from a
    // flip-flop throughout the access cycle; it then holds until the next
    // read, which keeps the bus quiet between transfers.
    always @(posedge ref_clk) begin
        if (rst) begin
            prdata <= `ATV_RD_RST;
        end else if (setup_cycle && !pwrite) begin
            prdata <= rd_d;
        end
    end

    // ****************************************
    // Observation pins
    // ****************************************
    wire [3:0] first_pin_source_select;
    wire [3:0] second_pin_source_select;
    assign first_pin_source_select = pin_source_select_register[`ATV_SEL1_HI:`ATV_SEL1_LO];
    assign second_pin_source_select = pin_source_select_register[`ATV_SEL2_HI:`ATV_SEL2_LO];

    atv_pin_mux u_pin1 ( // [RL1] [RL8]
        .ref_clk(ref_clk),
        .rst(rst),
        .source_select(first_pin_source_select),
        .dac_value(first_dac_test_value_q),
        .dac_level_q(first_observe_pin_level),
        .pin_oe_q(first_observe_pin_oe)
    );
    atv_pin_mux u_pin2 ( // [RL2] [RL8]
        .ref_clk(ref_clk),
        .rst(rst),
        .source_select(second_pin_source_select),
        .dac_value(second_dac_test_value_q),
        .dac_level_q(second_observe_pin_level),
        .pin_oe_q(second_observe_pin_oe)
    );
endmodule

// *** testbench/atv_test_regs_checker.sv ***
`timescale 1ns/1ps
// ****************
// Port checks of the test register bank.
// ****************
module atv_test_regs_checker (
    input wire ref_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [9:0] paddr,
    input wire pready,
    input wire [31:0] prdata,
    input wire pslverr,
    input wire [7:0] pin_source_select_register,
    input wire [5:0] first_observe_pin_level,
    input wire first_observe_pin_oe,
    input wire [5:0] second_observe_pin_level,
    input wire second_observe_pin_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire rs = psel && !penable && !pwrite;
    wire [3:0] s1 = pin_source_select_register[7:4];
    wire [3:0] s2 = pin_source_select_register[3:0];
    AST_OE1: assert property (s1 == 4'h1 |=> first_observe_pin_oe)
        else $error("pin one not driven");
    AST_OE2: assert property (s2 == 4'h1 |=> second_observe_pin_oe)
        else $error("pin two not driven");
    AST_TRI1: assert property (s1 != 4'h1 |=> !first_observe_pin_oe)
        else $error("pin one driven");
    AST_TRI2: assert property (s2 != 4'h1 |=> !second_observe_pin_oe)
        else $error("pin two driven");
    AST_LVL1: assert property (!first_observe_pin_oe |-> first_observe_pin_level == 6'h00)
        else $error("pin one level while released");
    AST_LVL2: assert property (!second_observe_pin_oe |-> second_observe_pin_level == 6'h00)
        else $error("pin two level while released");
    AST_TOP: assert property (rs && (paddr == 10'h0E4 || paddr == 10'h0E8) |=> prdata[7:6] == 2'h0)
        else $error("dac top bits set");
    AST_PROD: assert property (rs && paddr == 10'h0F8 |=> prdata == 32'h00000003)
        else $error("production value wrong");
    AST_ERR: assert property (pslverr |-> psel && penable && pready)
        else $error("error outside access");
    AST_UP: assert property (rs |=> prdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    cover property (psel && penable && pwrite);
    cover property (first_observe_pin_oe && second_observe_pin_oe);
    cover property (pslverr);
endmodule
bind atv_test_regs atv_test_regs_checker chk (.ref_clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pready, .prdata, .pslverr, .pin_source_select_register,
    .first_observe_pin_level, .first_observe_pin_oe, .second_observe_pin_level,
    .second_observe_pin_oe);

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
// ****************
// Bench for the test register bank.
// ****************
module tb_top;
    reg ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
    reg [9:0] paddr = 0;
    reg [31:0] pwdata = 0, rd;
    reg [3:0] ai = 0, aq = 0;
    reg [7:0] sel = 0;
    wire pready, pslverr, o1, o2;
    wire [31:0] prdata;
    wire [5:0] l1, l2;
    integer errors = 0, checks_done = 0, cyc = 0, i;
    atv_test_regs dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .adc_i_sample(ai), .adc_q_sample(aq),
        .pin_source_select_register(sel), .first_observe_pin_level(l1),
        .first_observe_pin_oe(o1), .second_observe_pin_level(l2), .second_observe_pin_oe(o2));
    initial forever #20 ref_clk = ~ref_clk;
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("[ERR] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // Each transfer opens on a fresh edge so no strobe is assigned twice in one step.
    task apb(input w, input [9:0] a, input [31:0] d);
        begin
            @(posedge ref_clk);
            psel <= 1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge ref_clk);
            penable <= 1;
            @(posedge ref_clk);
            while (pready !== 1'b1)
                @(posedge ref_clk);
            rd = prdata;
            err = pslverr;
            psel <= 0;
            penable <= 0;
        end
    endtask
    task t_reset;
        begin
            for (i = 0; i < 7; i = i + 1) begin
                apb(0, 10'h0E4 + 4 * i, 0);
                chk(rd, (i == 5) ? 3 : ((i == 3) ? 32'hFF : 0));
            end
            $display("reset test done");
        end
    endtask
    task t_dac;
        begin
            apb(1, 10'h0E4, 32'hFFFFFFFF);
            apb(1, 10'h0E8, 32'h000000AA);
            apb(0, 10'h0E4, 0);
            chk(rd, 32'h3F);
            apb(0, 10'h0E8, 0);
            chk(rd, 32'h2A);
            for (i = 0; i < 16; i = i + 1) begin
                sel <= {i[3:0], i[3:0]};
                repeat (3) @(posedge ref_clk);
                chk({o1, l1, o2, l2}, (i == 1) ? 14'h3FEA : 0);
            end
            sel <= 8'h10;
            repeat (3) @(posedge ref_clk);
            chk({o1, l1, o2, l2}, 14'h3F80);
            sel <= 8'h01;
            repeat (3) @(posedge ref_clk);
            chk({o1, l1, o2, l2}, 14'h006A);
            $display("dac test done");
        end
    endtask
    task t_adc;
        begin
            ai <= 4'hA;
            aq <= 4'h5;
            apb(0, 10'h0EC, 0);
            chk(rd, 32'hA5);
            apb(1, 10'h0EC, 32'hFF);
            ai <= 4'h3;
            aq <= 4'hC;
            apb(0, 10'h0EC, 0);
            chk(rd, 32'h3C);
            $display("adc test done");
        end
    endtask
    task t_prod;
        begin
            apb(1, 10'h0F8, 32'hFF);
            apb(0, 10'h0F8, 0);
            chk(rd, 32'h3);
            chk(err, 0);
            apb(0, 10'h100, 0);
            chk(rd, 0);
            chk(err, 1);
            $display("production test done");
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", checks_done, errors);
            if (errors == 0 && checks_done > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            errors = errors + 1;
            complete_run;
        end
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 0;
        t_reset;
        t_dac;
        t_adc;
        t_prod;
        complete_run;
    end
endmodule
